// [rtl/icf_edge_det.sv]
// Purpose: Per-input edge detector with selectable polarity.
// Assumes: Pins are synchronous to pclk.
// Notes:   Changing the polarity alone never yields an event.
`timescale 1ns/10ps
`default_nettype none
module icf_edge_det #(
  parameter int N = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] falling_sel,
  output var  logic [N-1:0] evt
);
  import icf_pkg::*;

  logic [N-1:0] prev;
  logic [N-1:0] next_evt;
  logic         armed;

  // The first sample after reset only loads the history, so a pin that
  // idles high is not mistaken for a rising edge.
  assign next_evt = {N{armed}} &
                    ((falling_sel & prev & ~pin) |
                     (~falling_sel & ~prev & pin));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev  <= '0;
      evt   <= '0;
      armed <= 1'b0;
    end else begin
      prev  <= pin;
      evt   <= next_evt;
      armed <= 1'b1;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_chk
    a_fall_edge: assert property (@(posedge pclk) disable iff (!presetn)
      armed && falling_sel[i] && $fell(pin[i]) |=> evt[i])
      else $error("falling edge missed");
    a_rise_edge: assert property (@(posedge pclk) disable iff (!presetn)
      armed && !falling_sel[i] && $rose(pin[i]) |=> evt[i])
      else $error("rising edge missed");
  end

endmodule
`default_nettype wire

// [rtl/icf_pkg.sv]
// Purpose: Types and shared decode function of the interrupt slice.
// Assumes: Bit positions come from icf_regs.svh.
// Notes:   No constants live here, only types and the field decode function.
package icf_pkg;

  typedef logic [2:0] icf_prio_t;

  typedef struct packed {
    logic can_b_tx;
    logic can_a_tx;
    logic dma_ch7;
    logic dma_ch6;
    logic uart_b;
    logic uart_a;
  } icf_gate_t;

  typedef struct packed {
    logic      req;
    logic [1:0] id;
    icf_prio_t level;
  } icf_grant_t;

  function automatic icf_prio_t icf_field(input logic [15:0] r,
                                          input int unsigned lsb);
    return r[lsb +: 3];
  endfunction

endpackage

// [rtl/icf_prio_arb.sv]
// Purpose: Picks the highest-priority pending source, registered.
// Assumes: A level of zero means the source is off.
// Notes:   Ties go to the lowest index, so the order is fixed.
`timescale 1ns/10ps
`default_nettype none
module icf_prio_arb #(
  parameter int N = 4
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [N-1:0]         req,
  input  wire logic [N-1:0][2:0]    prio,
  output icf_pkg::icf_grant_t       grant
);
  import icf_pkg::*;

  icf_grant_t next_grant;

  // Strict compare keeps the earlier winner on a tie and never lets
  // a zero level win, since the search starts from level zero.
  always_comb begin
    next_grant = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (prio[i] > next_grant.level)) begin
        next_grant.req   = 1'b1;
        next_grant.id    = 2'(i);
        next_grant.level = prio[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant <= '0;
    end else begin
      grant <= next_grant;
    end
  end

endmodule
`default_nettype wire

// [rtl/icf_regs.svh]
// Purpose: Register offsets, bit positions, masks and reset values.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Registers are 16 bits wide; bits 31:16 always read zero.
`ifndef ICF_REGS_SVH
`define ICF_REGS_SVH

`define ICF_AW            12
`define ICF_OFS_CTRL2     12'h000
`define ICF_OFS_EN4       12'h004
`define ICF_OFS_PRIO12    12'h008
`define ICF_OFS_STAT      12'h00c
`define ICF_OFS_MASK      12'h010
`define ICF_OFS_GRANT     12'h014

`define ICF_CTRL2_ALT     15
`define ICF_CTRL2_HOLD    14
`define ICF_CTRL2_WMASK   16'h801f
`define ICF_HOLD_MASK     16'h4000
`define ICF_CTRL2_RESET   16'h0000

`define ICF_EN4_CANB      7
`define ICF_EN4_CANA      6
`define ICF_EN4_DMA7      5
`define ICF_EN4_DMA6      4
`define ICF_EN4_UARTB     2
`define ICF_EN4_UARTA     1
`define ICF_EN4_WMASK     16'h00f6
`define ICF_EN4_RESET     16'h0000

`define ICF_T8_LSB        12
`define ICF_I2CM_LSB      8
`define ICF_I2CS_LSB      4
`define ICF_T7_LSB        0
`define ICF_PRIO12_WMASK  16'h7777
`define ICF_PRIO12_RESET  16'h4444

`define ICF_STAT_WMASK    16'h001f
`define ICF_STAT_RESET    16'h0000
`define ICF_MASK_RESET    16'h0000

`endif

// [rtl/icf_slice.sv]
// Purpose: Interrupt configuration slice with APB register access.
// Assumes: All inputs synchronous to pclk; APB3 without pstrb.
// Notes:   Zero-wait APB; read data is captured in the setup cycle.
// Operation
// - Read-only status of interrupt-disable instruction.
// - Per-input polarity: one falling, zero rising.
// - Two CAN transmit request enable bits.
// - Two UART error request enable bits.
// - Three-bit priority, seven highest, one lowest.
// - Priority zero disables the source entirely.
// - Timer eight at 14:12, timer seven 2:0.
// - Second I2C master 10:8, slave 6:4.
// - Unimplemented bits read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "icf_regs.svh"
module icf_slice (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`ICF_AW-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  core_irq_disable,
  input  wire logic [4:0]            ext_irq_pin,
  input  wire icf_pkg::icf_gate_t    periph_req,
  output icf_pkg::icf_gate_t         periph_req_gated,
  input  wire logic [3:0]            prio_src_req,
  output icf_pkg::icf_grant_t        core_grant,
  output logic                       alt_vector_select,
  output logic [2:0]                 vec_index,
  output logic                       irq
);
  import icf_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Register state.

  logic [15:0] ctrl2;
  logic [15:0] en4;
  logic [15:0] prio12;
  logic [15:0] stat;
  logic [15:0] imask;
  logic [15:0] next_ctrl2;
  logic [15:0] next_en4;
  logic [15:0] next_prio12;
  logic [15:0] next_stat;
  logic [15:0] next_imask;
  logic [15:0] stat_clr;
  logic [15:0] rd_ctrl2;
  logic [15:0] rd_grant;
  logic [15:0] rd_word;
  logic [4:0]  ext_evt;
  logic [3:0][2:0] prio_vec;
  icf_gate_t   en_gate;

  //////////////////////////////////////////////////////////////////////
  // APB decode.

  logic setup;
  logic acc;
  logic wr_en;
  logic hit_c2;
  logic hit_en;
  logic hit_pr;
  logic hit_st;
  logic hit_mk;
  logic hit_gr;
  logic hit_any;

  assign setup   = psel & ~penable;
  assign acc     = psel & penable;
  assign wr_en   = acc & pwrite;
  assign hit_c2  = (paddr == `ICF_OFS_CTRL2);
  assign hit_en  = (paddr == `ICF_OFS_EN4);
  assign hit_pr  = (paddr == `ICF_OFS_PRIO12);
  assign hit_st  = (paddr == `ICF_OFS_STAT);
  assign hit_mk  = (paddr == `ICF_OFS_MASK);
  assign hit_gr  = (paddr == `ICF_OFS_GRANT);
  assign hit_any = hit_c2 | hit_en | hit_pr | hit_st | hit_mk | hit_gr;

  // Every access completes in its first access cycle.
  assign pready  = acc;
  assign pslverr = acc & ~hit_any;

  //////////////////////////////////////////////////////////////////////
  // Write paths. Masks drop writes to unimplemented and read-only bits.

  assign next_ctrl2 = (wr_en & hit_c2) ?
                      (pwdata[15:0] & `ICF_CTRL2_WMASK) : ctrl2;
  assign next_en4 = (wr_en & hit_en) ?
                    (pwdata[15:0] & `ICF_EN4_WMASK) : en4;
  assign next_prio12 = (wr_en & hit_pr) ?
                       (pwdata[15:0] & `ICF_PRIO12_WMASK) : prio12;
  assign next_imask = (wr_en & hit_mk) ?
                      (pwdata[15:0] & `ICF_STAT_WMASK) : imask;

  // A write of one clears a status bit, but a new edge in the same
  // cycle sets it again, so no event is lost to a late clear.
  assign stat_clr  = (wr_en & hit_st) ?
                     (pwdata[15:0] & `ICF_STAT_WMASK) : 16'h0000;
  assign next_stat = (stat & ~stat_clr) | {11'h000, ext_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2  <= `ICF_CTRL2_RESET;
      en4    <= `ICF_EN4_RESET;
      prio12 <= `ICF_PRIO12_RESET;
      stat   <= `ICF_STAT_RESET;
      imask  <= `ICF_MASK_RESET;
    end else begin
      ctrl2  <= next_ctrl2;
      en4    <= next_en4;
      prio12 <= next_prio12;
      stat   <= next_stat;
      imask  <= next_imask;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read paths.

  assign rd_ctrl2 = ctrl2 |
                    (core_irq_disable ? `ICF_HOLD_MASK : 16'h0000);
  assign rd_grant = {7'h00, core_grant.req, 2'h0, core_grant.id,
                     1'b0, core_grant.level};
  assign rd_word  = hit_c2 ? rd_ctrl2 :
                    hit_en ? en4 :
                    hit_pr ? prio12 :
                    hit_st ? stat :
                    hit_mk ? imask :
                    hit_gr ? rd_grant : 16'h0000;

  // Capturing in setup keeps prdata a flop and still answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {16'h0000, rd_word};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Vector table and external edge sources.

  assign alt_vector_select = ctrl2[`ICF_CTRL2_ALT];
  assign vec_index = {alt_vector_select, core_grant.id};

  icf_edge_det #(
    .N (5)
  ) u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin         (ext_irq_pin),
    .falling_sel (ctrl2[4:0]),
    .evt         (ext_evt)
  );

  assign irq = |(stat & imask);

  //////////////////////////////////////////////////////////////////////
  // Enable gates for request lines without a priority field.

  assign en_gate = {en4[`ICF_EN4_CANB], en4[`ICF_EN4_CANA],
                    en4[`ICF_EN4_DMA7], en4[`ICF_EN4_DMA6],
                    en4[`ICF_EN4_UARTB], en4[`ICF_EN4_UARTA]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_req_gated <= '0;
    end else begin
      periph_req_gated <= periph_req & en_gate;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Priority arbitration. Index 0 timer seven, 1 I2C slave,
  // 2 I2C master, 3 timer eight.

  assign prio_vec = {icf_field(prio12, `ICF_T8_LSB),
                     icf_field(prio12, `ICF_I2CM_LSB),
                     icf_field(prio12, `ICF_I2CS_LSB),
                     icf_field(prio12, `ICF_T7_LSB)};

  icf_prio_arb #(
    .N (4)
  ) u_arb (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (prio_src_req),
    .prio    (prio_vec),
    .grant   (core_grant)
  );

  //////////////////////////////////////////////////////////////////////
  // Checks, with helper history of the arbiter inputs.

  logic [3:0]      req_hist;
  logic [3:0][2:0] prio_hist;
  logic            beaten;
  logic            live;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_hist  <= '0;
      prio_hist <= '0;
    end else begin
      req_hist  <= prio_src_req;
      prio_hist <= prio_vec;
    end
  end

  always_comb begin
    beaten = 1'b0;
    live   = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (req_hist[i] && (prio_hist[i] != 3'h0)) begin
        live = 1'b1;
      end
      if (req_hist[i] && (prio_hist[i] > core_grant.level)) begin
        beaten = 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_setup(hit);
    setup && !pwrite && hit;
  endsequence

  a_alt_select: assert property (
    wr_en && hit_c2 |=> alt_vector_select == $past(pwdata[15]) &&
                        vec_index[2] == $past(pwdata[15]))
    else $error("vector table select not taken");

  a_hold_read: assert property (
    s_rd_setup(hit_c2) |=> prdata[14] == $past(core_irq_disable))
    else $error("disable status misread");

  a_hold_nowrite: assert property (
    s_rd_setup(hit_c2 && !core_irq_disable) |=> !prdata[14])
    else $error("disable status took a write");

  a_can_gate: assert property (
    periph_req.can_a_tx != periph_req.can_b_tx || 1'b1 |=>
      periph_req_gated.can_b_tx ==
        $past(periph_req.can_b_tx && en4[`ICF_EN4_CANB]) &&
      periph_req_gated.can_a_tx ==
        $past(periph_req.can_a_tx && en4[`ICF_EN4_CANA]))
    else $error("CAN request gate wrong");

  a_dma_gate: assert property (
    periph_req.dma_ch7 && en4[`ICF_EN4_DMA7] |=> periph_req_gated.dma_ch7)
    else $error("DMA 7 completion blocked");

  a_dma_block: assert property (
    !en4[`ICF_EN4_DMA6] |=> !periph_req_gated.dma_ch6)
    else $error("DMA 6 completion leaked");

  a_uart_gate: assert property (
    !en4[`ICF_EN4_UARTA] || !periph_req.uart_a |=> !periph_req_gated.uart_a)
    else $error("UART error leaked");

  a_prio_level: assert property (
    core_grant.req |-> core_grant.level == prio_hist[core_grant.id])
    else $error("granted level differs from field");

  a_zero_off: assert property (
    core_grant.req |-> core_grant.level != 3'h0 && req_hist[core_grant.id])
    else $error("disabled source granted");

  a_t_fields: assert property (
    wr_en && hit_pr |=>
      icf_field(prio12, `ICF_T8_LSB) == $past(pwdata[14:12]) &&
      icf_field(prio12, `ICF_T7_LSB) == $past(pwdata[2:0]))
    else $error("timer priority field misplaced");

  a_i2c_fields: assert property (
    wr_en && hit_pr |=>
      icf_field(prio12, `ICF_I2CM_LSB) == $past(pwdata[10:8]) &&
      icf_field(prio12, `ICF_I2CS_LSB) == $past(pwdata[6:4]))
    else $error("I2C priority field misplaced");

  a_unimpl_zero: assert property (
    s_rd_setup(hit_en || hit_pr) |=> prdata[31:16] == 16'h0000 &&
      (prdata[15:0] & ~($past(hit_en) ? `ICF_EN4_WMASK :
                        `ICF_PRIO12_WMASK)) == 16'h0000)
    else $error("unimplemented bit reads nonzero");

  a_best_wins: assert property (
    !beaten && (!live || core_grant.req))
    else $error("higher priority request passed over");

endmodule
`default_nettype wire

// [verification/icf_src_model.sv]
// Purpose: Behavioural model of the request sources and the core.
// Assumes: Levels change just after a rising pclk edge.
// Notes:   A lag in cycles lets a source answer slowly.
`timescale 1ns/10ps
`default_nettype none
module icf_src_model (
  input  wire logic          pclk,
  output logic [4:0]         ext_irq_pin,
  output icf_pkg::icf_gate_t periph_req,
  output logic [3:0]         prio_src_req,
  output logic               core_irq_disable
);
  import icf_pkg::*;

  initial begin
    ext_irq_pin = 5'h00;
    periph_req = '0;
    prio_src_req = 4'h0;
    core_irq_disable = 1'b0;
  end

  // Inputs are synchronous, so every change lands right after an edge.
  task automatic put(input logic [4:0] pin, input icf_gate_t pr,
                     input logic [3:0] sr, input logic dis, input int lag);
    repeat (lag) @(posedge pclk);
    @(posedge pclk);
    ext_irq_pin <= pin;
    periph_req <= pr;
    prio_src_req <= sr;
    core_irq_disable <= dis;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench of the interrupt configuration slice.
// Assumes: Zero-wait APB slave; sources come from icf_src_model.
// Notes:   Expected values are worked out here from the register map.
`timescale 1ns/10ps
`default_nettype none
`include "icf_regs.svh"
module tb;
  import icf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, en, pr, s, t;
  icf_gate_t   gated, preq;
  icf_grant_t  grant;
  logic        alt, irq, err, dis;
  logic [2:0]  vidx;
  logic [4:0]  pin, wpin;
  logic [3:0]  sreq, wsreq;
  icf_gate_t   wpreq;
  logic        wdis;
  int          miscompares, tests_run, seed, i;

  icf_slice uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_irq_disable(wdis), .ext_irq_pin(wpin), .periph_req(wpreq),
    .periph_req_gated(gated), .prio_src_req(wsreq), .core_grant(grant),
    .alt_vector_select(alt), .vec_index(vidx), .irq(irq));
  icf_src_model src (.pclk(pclk), .ext_irq_pin(wpin), .periph_req(wpreq),
    .prio_src_req(wsreq), .core_irq_disable(wdis));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic put(input int n);
    src.put(pin, preq, sreq, dis, 0);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Highest nonzero level wins; a strict compare keeps the lowest index.
  function automatic logic [5:0] exp_grant(input logic [3:0] rq,
                                           input logic [15:0] p);
    logic [2:0] b;
    logic [1:0] id;
    logic       v;
    b = 3'h0;
    id = 2'h0;
    v = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (rq[k] && p[4*k +: 3] > b) begin
        b = p[4*k +: 3];
        id = 2'(k);
        v = 1'b1;
      end
    end
    return {v, id, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 84856;
    miscompares = 0;
    tests_run = 0;
    {psel, penable, pwrite, dis, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pin = 5'h00;
    preq = '0;
    sreq = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`ICF_OFS_CTRL2, 32'h0000_0000);
    rdchk(`ICF_OFS_EN4, 32'h0000_0000);
    rdchk(`ICF_OFS_PRIO12, 32'h0000_4444);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, `ICF_OFS_CTRL2, 32'hffff_ffff);
    dis = 1'b1;
    put(2);
    rdchk(`ICF_OFS_CTRL2, 32'h0000_c01f);
    chk(32'({alt, vidx[2]}), 32'h0000_0003);
    dis = 1'b0;
    put(2);
    apb(1'b1, `ICF_OFS_CTRL2, 32'h0000_4000);
    rdchk(`ICF_OFS_CTRL2, 32'h0000_0000);
    chk(32'({alt, vidx[2]}), 32'h0000_0000);
    apb(1'b1, `ICF_OFS_EN4, 32'hffff_ffff);
    rdchk(`ICF_OFS_EN4, 32'h0000_00f6);
    for (i = 0; i < 16; i++) begin
      en = (i == 0) ? 32'h0000_0000 : $random(seed);
      apb(1'b1, `ICF_OFS_EN4, en);
      preq = (i < 2) ? 6'h3f : 6'($random(seed));
      put(2);
      chk(32'(gated), 32'(preq & {en[7:4], en[2:1]}));
    end
    apb(1'b1, `ICF_OFS_PRIO12, 32'hffff_ffff);
    rdchk(`ICF_OFS_PRIO12, 32'h0000_7777);
    for (i = 0; i < 24; i++) begin
      pr = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_5555 : $random(seed);
      sreq = (i < 2) ? 4'hf : 4'($random(seed));
      apb(1'b1, `ICF_OFS_PRIO12, pr);
      put(2);
      t = 32'(exp_grant(sreq, pr[15:0]));
      chk(32'(grant), t);
      chk(32'(vidx), (t >> 3) & 32'h0000_0003);
      rdchk(`ICF_OFS_GRANT,
            32'({t[5], 2'h0, t[4:3], 1'h0, t[2:0]}));
    end
    apb(1'b1, `ICF_OFS_MASK, 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      s = (i == 0) ? 32'h0000_001f : (i == 1) ? 32'h0 : ($random(seed) & 31);
      t = (i < 2) ? 32'h0000_001f : (($random(seed) & 31) | 1);
      apb(1'b1, `ICF_OFS_CTRL2, s);
      pin = s[4:0];
      put(3);
      apb(1'b1, `ICF_OFS_STAT, 32'h0000_001f);
      rdchk(`ICF_OFS_STAT, 32'h0000_0000);
      pin = s[4:0] ^ t[4:0];
      put(3);
      rdchk(`ICF_OFS_STAT, t);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, `ICF_OFS_MASK, 32'h0000_001f);
      put(1);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, `ICF_OFS_STAT, t);
      pin = s[4:0];
      put(3);
      rdchk(`ICF_OFS_STAT, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, `ICF_OFS_MASK, 32'h0000_0000);
    end
    pin = 5'h1f;
    put(3);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    put(2);
    rdchk(`ICF_OFS_STAT, 32'h0000_0000);
    rdchk(`ICF_OFS_PRIO12, 32'h0000_4444);
    end_of_test();
  end
endmodule
`default_nettype wire
